// *** common/cd_input_map.svh ***
// Purpose: Register indices, field positions and counts of the sector input writer.
// Assumes: Byte address of a register is four times its index.
// Notes: Definitions only.
//
// What this block does
// - Bit 7 picks I2S or alternate framing.
// - Divider code sets bit clock ratio.
// - Sub-header select picks copies for flags.
// - Length code sets 2352 or 2064 count.
// - Swap bit swaps received bytes.
// - Clock bit inverts receive clock.
// - Sector bytes at offsets below 2352 go to RAM.
// - Block written at current 2560-byte segment.
// - Pointer steps if enabled; counter always decrements.
// - Pointer holds when stepping is disabled.
// - Write-inhibit keeps updates, stores no data.
// - Previous pointer takes current at block end.
// - Group end reloads current set, raises event.
// - Decode off keeps input side reset.
// - Write request off stops writes and updates.
// - Correction bit selects full correction or checking.
// - Encode bit selects erasure encoder operation.
// - Bits 5,4,3 enable three correction options.
// - Detect data and flag syncs; interpolate.
// - Descramble data-disc sectors before writing.
// - No sync, no interpolation: extend, flag.
`ifndef CD_INPUT_MAP_SVH
`define CD_INPUT_MAP_SVH
`define IX_STATUS0 16'hff08
`define IX_HDR_ERR 16'hff09
`define IX_MAIN_CTRL 16'hff0d
`define IX_SYNC_CTRL 16'hff0e
`define IX_FMT_CTRL 16'hff0f
`define IX_IF_CFG 16'hff10
`define IX_CUR_HI 16'hff20
`define IX_CUR_LO 16'hff21
`define IX_PREV_HI 16'hff22
`define IX_PREV_LO 16'hff23
`define IX_OFF_HI 16'hff24
`define IX_OFF_LO 16'hff25
`define IX_NEXT_HI 16'hff26
`define IX_NEXT_LO 16'hff27
`define IX_CUR_CNT 16'hff60
`define IX_NEXT_CNT 16'hff61
`define MC_DECODE_EN 7
`define MC_MISCOR 5
`define MC_AUTOFORM 4
`define MC_ERASURE 3
`define MC_WR_REQ 2
`define MC_ECC 1
`define MC_ENCODE 0
`define SC_INTERP_EN 7
`define SC_DETECT_EN 6
`define SC_AUDIO_SYNC 5
`define FC_DESCR_EN 1
`define IF_FMT_SEL 7
`define IF_SUBSEL 4
`define IF_SWAP 1
`define IF_WCLK_INV 0
`define SEG_INC 7
`define SEG_WR_INH 6
`define SEG_HI_MASK 8'hdf
`define ST0_LONG_BLK 4
`define LEN_FULL 12'd2352
`define LEN_SHORT 12'd2064
`define SEG_BYTES 25'd2560
`define SYNC_LAST 12'd11
`define SCR_START 12'd12
`define SUB1_FIRST 12'd16
`define SUB2_FIRST 12'd20
`define SCR_SEED 15'h0001
`endif

// *** common/cd_input_pkg.sv ***
// Purpose: Types shared by the sector input writer.
// Assumes: Nothing beyond the map header.
// Notes: Constants live in the map header.
package cd_input_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [31:0] word_t;
  typedef enum logic [1:0] {SYNC_NONE, SYNC_DATA, SYNC_EXT, SYNC_INTERP} sync_kind_t;
endpackage

// *** core/cd_sector_input_writer.sv ***
// Purpose: Receive serial sector data, find syncs, descramble, write segments.
// Assumes: Serial pins are synchronous to pclk; APB slave answers with no wait.
// Notes: Error corrector itself lives elsewhere; its controls are outputs.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`include "cd_input_map.svh"
module cd_sector_input_writer (
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire cd_input_pkg::word_t pwdata,
  output logic pready,
  output cd_input_pkg::word_t prdata,
  output logic pslverr,
  // Serial front end.
  input wire logic serial_bit_clk,
  input wire logic serial_word_clk,
  input wire logic serial_data,
  input wire logic serial_byte_flag,
  input wire logic external_flag_input,
  // Buffer RAM write port.
  output logic mem_we,
  output logic [24:0] mem_addr,
  output cd_input_pkg::byte_t mem_wdata,
  // Sub-CPU event and corrector controls.
  output logic reload_pulse,
  output logic ecc_enable,
  output logic encode_mode,
  output logic miscorrection_fix_enable,
  output logic auto_form_enable,
  output logic erasure_enable
);
  import cd_input_pkg::*;

  // Register storage.
  byte_t main_control_q, sync_control_q, format_control_q, input_interface_config_q;
  byte_t cur_hi_q, cur_lo_q, prev_hi_q, prev_lo_q, next_hi_q, next_lo_q;
  byte_t cur_cnt_q, next_cnt_q, hdr_err_q, status0_q, prdata_q;
  logic pslverr_q;

  // Receiver and sector state.
  logic bclk_q, wclk_q, byte2_q, flag_q, mem_we_q, reload_q;
  logic [2:0] div_q;
  logic [3:0] bits_q, pat_q;
  logic [15:0] shift_q, word_q;
  logic [11:0] off_q;
  logic [14:0] scr_q;
  logic [24:0] mem_addr_q;
  byte_t mem_wdata_q;
  byte_t sub_q [4];

  // Configuration decode.
  wire decen = main_control_q[`MC_DECODE_EN];
  wire wrreq = main_control_q[`MC_WR_REQ];
  wire incen = cur_hi_q[`SEG_INC];
  wire wr_inhibit = cur_hi_q[`SEG_WR_INH];
  wire [1:0] div_code = input_interface_config_q[6:5];
  wire [1:0] len_code = input_interface_config_q[3:2];
  wire fmt_alt = input_interface_config_q[`IF_FMT_SEL];
  wire subsel = input_interface_config_q[`IF_SUBSEL];
  wire swap = input_interface_config_q[`IF_SWAP];
  wire wclk_inv = input_interface_config_q[`IF_WCLK_INV];
  wire [12:0] cur_seg = {cur_hi_q[4:0], cur_lo_q};
  wire [12:0] next_seg = {next_hi_q[4:0], next_lo_q};

  // Corrector controls follow the main control bits directly.
  assign ecc_enable = main_control_q[`MC_ECC];
  assign encode_mode = main_control_q[`MC_ENCODE];
  assign miscorrection_fix_enable = main_control_q[`MC_MISCOR];
  assign auto_form_enable = main_control_q[`MC_AUTOFORM];
  assign erasure_enable = main_control_q[`MC_ERASURE];

  // APB decode; index is the byte address divided by four.
  wire setup = psel && !penable;
  wire apb_wr = psel && penable && pwrite;
  wire [15:0] idx = paddr[17:2];
  wire [15:0] widx = paddr[17:2];
  wire wbyte_ok = (paddr[1:0] == 2'b00);
  assign pready = 1'b1;
  assign prdata = {24'h000000, prdata_q};
  assign pslverr = pslverr_q;

  // Read multiplexer; the interface configuration is write only.
  logic [7:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (idx)
      `IX_STATUS0: rd_mux = status0_q;
      `IX_HDR_ERR: rd_mux = hdr_err_q;
      `IX_MAIN_CTRL: rd_mux = main_control_q;
      `IX_SYNC_CTRL: rd_mux = sync_control_q;
      `IX_FMT_CTRL: rd_mux = format_control_q;
      `IX_IF_CFG: rd_mux = 8'h00;
      `IX_CUR_HI: rd_mux = cur_hi_q;
      `IX_CUR_LO: rd_mux = cur_lo_q;
      `IX_PREV_HI: rd_mux = prev_hi_q;
      `IX_PREV_LO: rd_mux = prev_lo_q;
      `IX_OFF_HI: rd_mux = {4'h0, off_q[11:8]};
      `IX_OFF_LO: rd_mux = off_q[7:0];
      `IX_NEXT_HI: rd_mux = next_hi_q;
      `IX_NEXT_LO: rd_mux = next_lo_q;
      `IX_CUR_CNT: rd_mux = cur_cnt_q;
      `IX_NEXT_CNT: rd_mux = next_cnt_q;
      default: begin
        rd_mux = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read data and error are latched in setup and shown in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 8'h00;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= rd_mux;
      pslverr_q <= !rd_hit || !wbyte_ok;
    end
  end

  // Receive clock edge, divider and word framing.
  wire bclk_edge = wclk_inv ? (bclk_q && !serial_bit_clk) : (!bclk_q && serial_bit_clk);
  logic [2:0] div_mask;
  always_comb begin
    unique case (div_code)
      2'b00: div_mask = 3'd1;
      2'b01: div_mask = 3'd3;
      2'b10: div_mask = 3'd7;
      2'b11: div_mask = 3'd0;
    endcase
  end
  wire bit_take = bclk_edge && ((div_q & div_mask) == div_mask);
  wire ws_change = bit_take && (serial_word_clk != wclk_q);
  wire word_done = bit_take && !ws_change && (bits_q == 4'd15);

  // Serial shifter; held in reset while decoding is off.
  // The bit seen with a word clock change is dropped in I2S framing, kept as MSB otherwise.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_q <= 1'b0;
      wclk_q <= 1'b0;
      div_q <= 3'd0;
      bits_q <= 4'd0;
      shift_q <= 16'h0000;
    end else if (!decen) begin
      bclk_q <= serial_bit_clk; // Follows the pin so enabling makes no false edge.
      wclk_q <= 1'b0;
      div_q <= 3'd0;
      bits_q <= 4'd0;
      shift_q <= 16'h0000;
    end else begin
      bclk_q <= serial_bit_clk;
      if (bclk_edge)
        div_q <= div_q + 3'd1;
      if (ws_change) begin
        wclk_q <= serial_word_clk;
        bits_q <= fmt_alt ? 4'd1 : 4'd0;
        if (fmt_alt)
          shift_q <= {shift_q[14:0], serial_data};
      end else if (bit_take) begin
        shift_q <= {shift_q[14:0], serial_data};
        bits_q <= bits_q + 4'd1;
      end
    end
  end

  // Each word yields two bytes over two cycles, order set by the swap bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= 16'h0000;
      byte2_q <= 1'b0;
      flag_q <= 1'b0;
    end else if (!decen) begin
      byte2_q <= 1'b0;
    end else begin
      byte2_q <= byte1_q;
      if (word_done) begin
        word_q <= {shift_q[14:0], serial_data};
        flag_q <= serial_byte_flag;
      end
    end
  end
  logic byte1_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      byte1_q <= 1'b0;
    else
      byte1_q <= decen && word_done;
  end
  wire byte_v = byte1_q || (byte2_q && !byte1_q);
  wire first_byte = byte1_q;
  wire [7:0] byte_d = (first_byte ^ swap) ? word_q[15:8] : word_q[7:0];
  wire byte_skip = (len_code == 2'b11) && flag_q;

  // Sector length and sync pattern tracking.
  wire [11:0] modulo = (len_code == 2'b00) ? `LEN_FULL : `LEN_SHORT;
  wire pat_ff = (pat_q != 4'd0) && (pat_q <= 4'd10) && (byte_d == 8'hff);
  wire data_sync = sync_control_q[`SC_DETECT_EN] && !sync_control_q[`SC_AUDIO_SYNC]
                   && (pat_q == 4'd11) && (byte_d == 8'h00);
  wire ext_sync = sync_control_q[`SC_DETECT_EN] && external_flag_input;
  wire interp = sync_control_q[`SC_INTERP_EN] && (off_q >= modulo);
  sync_kind_t skind;
  always_comb begin
    if (!byte_v)
      skind = SYNC_NONE;
    else if (data_sync)
      skind = SYNC_DATA;
    else if (ext_sync)
      skind = SYNC_EXT;
    else if (interp)
      skind = SYNC_INTERP;
    else
      skind = SYNC_NONE;
  end
  wire sync_hit = (skind != SYNC_NONE);
  wire [11:0] wr_off = (skind == SYNC_DATA) ? `SYNC_LAST : sync_hit ? 12'd0 : off_q;
  wire long_blk = byte_v && !sync_hit && !sync_control_q[`SC_INTERP_EN]
                  && (off_q >= modulo);

  // Descrambler key for this byte and the advanced generator state.
  function automatic logic [22:0] scr_step(input logic [14:0] s);
    logic [14:0] t;
    logic [7:0] k;
    t = s;
    k = 8'h00;
    for (int i = 0; i < 8; i++) begin
      k[i] = t[0];
      t = {t[0] ^ t[1], t[14:1]};
    end
    return {t, k};
  endfunction
  wire [14:0] scr_base = scr_q;
  wire [22:0] scr_nx = scr_step(scr_base);
  wire descr = format_control_q[`FC_DESCR_EN] && !sync_control_q[`SC_AUDIO_SYNC]
               && (wr_off >= `SCR_START);
  wire [7:0] out_byte = descr ? (byte_d ^ scr_nx[7:0]) : byte_d;

  // Pointer update at each sync while decoding and writing are requested.
  wire sync_upd = sync_hit && decen && wrreq;
  wire [7:0] cnt_dec = cur_cnt_q - 8'd1;
  wire reload = sync_upd && (cnt_dec == 8'h00);
  wire [12:0] seg_inc = cur_seg + 13'd1;
  wire [12:0] seg_use = !sync_upd ? cur_seg : reload ? next_seg : incen ? seg_inc : cur_seg;
  wire wr_ok = decen && wrreq && !wr_inhibit && byte_v && !byte_skip
               && (wr_off < `LEN_FULL);
  wire [24:0] base = 25'(seg_use) * `SEG_BYTES;
  wire [24:0] addr_d = base + {13'h0000, wr_off};

  // Byte offset, pattern tracker, descrambler and write port.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      off_q <= 12'd0;
      pat_q <= 4'd0;
      scr_q <= `SCR_SEED;
      mem_we_q <= 1'b0;
      mem_addr_q <= 25'd0;
      mem_wdata_q <= 8'h00;
    end else if (!decen) begin
      off_q <= 12'd0;
      pat_q <= 4'd0;
      scr_q <= `SCR_SEED;
      mem_we_q <= 1'b0;
    end else begin
      mem_we_q <= wr_ok;
      if (byte_v) begin
        pat_q <= (pat_ff || (pat_q == 4'd0 && byte_d == 8'h00)) ? pat_q + 4'd1
                 : (byte_d == 8'h00) ? 4'd1 : 4'd0;
        if (data_sync)
          pat_q <= 4'd0;
        if (!byte_skip || sync_hit)
          off_q <= wr_off + 12'd1;
        if (sync_hit)
          scr_q <= `SCR_SEED;
        else if (!byte_skip && (wr_off >= `SCR_START))
          scr_q <= scr_nx[22:8];
        mem_addr_q <= addr_d;
        mem_wdata_q <= out_byte;
      end
    end
  end
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign reload_pulse = reload_q;

  // Sub-header flags and long-block status.
  wire [11:0] s1 = wr_off - `SUB1_FIRST;
  wire [11:0] s2 = wr_off - `SUB2_FIRST;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdr_err_q <= 8'h00;
      status0_q <= 8'h00;
      sub_q <= '{default: 8'h00};
    end else if (!decen) begin
      hdr_err_q <= 8'h00;
      status0_q <= 8'h00;
    end else if (byte_v) begin
      if (sync_hit) begin
        hdr_err_q <= 8'h00;
        status0_q[`ST0_LONG_BLK] <= 1'b0;
      end
      if (long_blk)
        status0_q[`ST0_LONG_BLK] <= 1'b1;
      if (s1 < 12'd4) begin
        sub_q[s1[1:0]] <= byte_d;
        hdr_err_q[3 - s1[1:0]] <= flag_q;
      end
      if ((s2 < 12'd4) && !subsel)
        hdr_err_q[3 - s2[1:0]] <= hdr_err_q[3 - s2[1:0]] || flag_q
                                  || (sub_q[s2[1:0]] != byte_d);
    end
  end

  // Register writes; a software write in a sync cycle takes precedence.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_control_q <= 8'h00;
      sync_control_q <= 8'h00;
      format_control_q <= 8'h00;
      input_interface_config_q <= 8'h00;
      cur_hi_q <= 8'h00;
      cur_lo_q <= 8'h00;
      prev_hi_q <= 8'h00;
      prev_lo_q <= 8'h00;
      next_hi_q <= 8'h00;
      next_lo_q <= 8'h00;
      cur_cnt_q <= 8'h00;
      next_cnt_q <= 8'h00;
      reload_q <= 1'b0;
    end else begin
      reload_q <= reload;
      if (sync_upd) begin
        prev_hi_q <= cur_hi_q;
        prev_lo_q <= cur_lo_q;
        if (reload) begin
          cur_hi_q <= next_hi_q;
          cur_lo_q <= next_lo_q;
          cur_cnt_q <= next_cnt_q;
        end else begin
          cur_cnt_q <= cnt_dec;
          if (incen) begin
            cur_hi_q[4:0] <= seg_inc[12:8];
            cur_lo_q <= seg_inc[7:0];
          end
        end
      end
      if (apb_wr && wbyte_ok) begin
        unique case (widx)
          `IX_MAIN_CTRL: main_control_q <= pwdata[7:0];
          `IX_SYNC_CTRL: sync_control_q <= pwdata[7:0];
          `IX_FMT_CTRL: format_control_q <= pwdata[7:0];
          `IX_IF_CFG: input_interface_config_q <= pwdata[7:0];
          `IX_CUR_HI: cur_hi_q <= pwdata[7:0] & `SEG_HI_MASK;
          `IX_CUR_LO: cur_lo_q <= pwdata[7:0];
          `IX_PREV_HI: prev_hi_q <= pwdata[7:0] & `SEG_HI_MASK;
          `IX_PREV_LO: prev_lo_q <= pwdata[7:0];
          `IX_NEXT_HI: next_hi_q <= pwdata[7:0] & `SEG_HI_MASK;
          `IX_NEXT_LO: next_lo_q <= pwdata[7:0];
          `IX_CUR_CNT: cur_cnt_q <= pwdata[7:0];
          `IX_NEXT_CNT: next_cnt_q <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // Checks on the write path and the pointer set.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire quiet = !apb_wr;
  write_gate_a: assert property (mem_we |-> $past(decen && wrreq && !wr_inhibit))
    else $error("buffer write without request");
  inhibit_a: assert property (wr_inhibit && $past(wr_inhibit) |-> !mem_we)
    else $error("write seen while inhibited");
  prev_copy_a: assert property (sync_upd && quiet |=> {prev_hi_q, prev_lo_q} ==
                                $past({cur_hi_q, cur_lo_q}))
    else $error("previous pointer not loaded");
  seg_step_a: assert property (sync_upd && quiet && !reload && incen |=>
                               cur_seg == $past(seg_inc))
    else $error("segment did not step");
  seg_hold_a: assert property (sync_upd && quiet && !reload && !incen |=> $stable(cur_seg))
    else $error("segment moved while held");
  count_dec_a: assert property (sync_upd && quiet && !reload |=> cur_cnt_q ==
                                $past(cur_cnt_q) - 8'd1)
    else $error("block counter did not decrement");
  reload_a: assert property (reload && quiet |=> cur_seg == $past(next_seg) && reload_pulse
                             && cur_cnt_q == $past(next_cnt_q))
    else $error("reload from next set failed");
  decode_off_a: assert property (!decen && $past(!decen) |-> !mem_we && !reload_pulse)
    else $error("activity while decoding is off");
  write_len_a: assert property (wr_ok |-> wr_off < `LEN_FULL ##1 mem_we)
    else $error("write beyond sector length");
  div_one_a: assert property (div_code == 2'b11 && bclk_edge |-> bit_take)
    else $error("undivided clock lost an edge");
  reload_c: cover property (reload ##1 reload_pulse);
  interp_c: cover property (byte_v && skind == SYNC_INTERP);
  ext_sync_c: cover property (byte_v && skind == SYNC_EXT);
  long_blk_c: cover property (long_blk ##1 status0_q[`ST0_LONG_BLK]);
endmodule // cd_sector_input_writer

// *** sim/cd_frontend_model.sv ***
// Purpose: Serial front end that feeds sector bytes to the input writer.
// Assumes: Tasks are entered just after a rising pclk edge.
// Notes: The bit clock stands still between frames; flags stay clear.
`timescale 1ns/10ps
module cd_frontend_model (
  // Clock.
  input wire logic pclk,
  // Serial lines.
  output logic bit_clk,
  output logic word_clk,
  output logic data,
  output logic byte_flag,
  output logic sync_flag
);
  import cd_input_pkg::*;
  // Lines start low and quiet.
  initial begin
    bit_clk = 1'b0;
    word_clk = 1'b0;
    data = 1'b0;
    byte_flag = 1'b0;
    sync_flag = 1'b0;
  end
  // One bit held over n bit clock pulses; inv picks which edge is the active one.
  // Data moves one cycle after the inactive edge, so that edge would see the old bit.
  task automatic put_bit(input logic b, input int n, input logic inv, input int half);
    repeat (n) begin
      bit_clk <= inv;
      @(posedge pclk);
      data <= b;
      repeat (half - 1) @(posedge pclk);
      bit_clk <= ~inv;
      repeat (half) @(posedge pclk);
    end
  endtask
  // Words go out MSB first; I2S framing adds a leading bit that must be dropped.
  task automatic send(input byte_t q[$], input logic swap, input logic alt,
      input int n, input logic inv, input int half);
    logic [15:0] w;
    for (int i = 0; i < q.size(); i += 2) begin
      w = swap ? {q[i+1], q[i]} : {q[i], q[i+1]};
      word_clk <= ~word_clk;
      if (!alt) put_bit(~w[15], n, inv, half);
      for (int k = 15; k >= 0; k--) put_bit(w[k], n, inv, half);
    end
    data <= ~data; // A released line shows the inverse, never the last bit.
  endtask
endmodule // cd_frontend_model

// *** sim/test_cd_sector_input_writer.sv ***
// Purpose: Self-checking bench for the sector input writer.
// Assumes: The APB slave may answer at once; the front end model feeds serial data.
// Notes: Full-length sectors are not run; each frame is a sync plus a few bytes.
`timescale 1ns/10ps
`include "cd_input_map.svh"
module test_cd_sector_input_writer;
  import cd_input_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [17:0] paddr;
  word_t pwdata, prdata;
  logic sbclk, swclk, sdat, sbflag, sxflag;
  logic mem_we, reload_pulse, ecc_enable, encode_mode;
  logic miscorrection_fix_enable, auto_form_enable, erasure_enable;
  logic [24:0] mem_addr;
  byte_t mem_wdata;
  byte_t mem [int];
  int fails = 0, check_count = 0, wr_n = 0, rl_n = 0;
  cd_sector_input_writer dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .serial_bit_clk(sbclk), .serial_word_clk(swclk), .serial_data(sdat),
    .serial_byte_flag(sbflag), .external_flag_input(sxflag), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .reload_pulse(reload_pulse),
    .ecc_enable(ecc_enable), .encode_mode(encode_mode),
    .miscorrection_fix_enable(miscorrection_fix_enable),
    .auto_form_enable(auto_form_enable), .erasure_enable(erasure_enable));
  cd_frontend_model fe (.pclk(pclk), .bit_clk(sbclk), .word_clk(swclk), .data(sdat),
    .byte_flag(sbflag), .sync_flag(sxflag));
  // Clock of 8 ns period.
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;
  // Buffer RAM image and reload events as seen at the outputs.
  always @(posedge pclk) begin
    if (mem_we === 1'b1) begin
      mem[int'(mem_addr)] = mem_wdata;
      wr_n++;
    end
    if (reload_pulse === 1'b1) rl_n++;
  end
  // Compares and counts; any difference is reported at once.
  task automatic check(input word_t seen, input word_t exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic give_verdict;
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One APB transfer: setup, then access held until pready is seen high.
  task automatic apb(input logic wr, input logic [15:0] ix, input byte_t d,
      output word_t r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] ix, input byte_t d);
    word_t r;
    logic e;
    apb(1'b1, ix, d, r, e);
  endtask
  task automatic rd(input logic [15:0] ix, input byte_t exp);
    word_t r;
    logic e;
    apb(1'b0, ix, 8'h00, r, e);
    check(r, {24'h0, exp});
  endtask
  // Sets up the interface, then sends a data sync and one payload word.
  task automatic frame(input byte_t d0, input byte_t d1, input byte_t cfg, input int half);
    byte_t q[$];
    int n;
    n = (cfg[6:5] == 2'b11) ? 1 : 2 << cfg[6:5];
    q = {8'h00};
    repeat (10) q.push_back(8'hff);
    q.push_back(8'h00);
    q.push_back(d0);
    q.push_back(d1);
    wr(`IX_IF_CFG, cfg);
    mem.delete();
    wr_n = 0;
    fe.send(q, cfg[1], cfg[7], n, cfg[0], half);
    repeat (4) @(posedge pclk);
  endtask
  // Last sync byte and the payload in the given segment.
  task automatic chk_mem(input int seg, input byte_t d0, input byte_t d1);
    check(mem[seg * 2560 + 11], 32'h0);
    check(mem[seg * 2560 + 12], d0);
    check(mem[seg * 2560 + 13], d1);
  endtask
  // Reset values, unmapped and write-only places, corrector controls.
  task automatic t_regs;
    word_t r;
    logic e;
    byte_t v;
    rd(`IX_MAIN_CTRL, 8'h00);
    rd(`IX_CUR_CNT, 8'h00);
    apb(1'b0, 16'hff30, 8'h00, r, e);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    wr(`IX_IF_CFG, 8'h60);
    rd(`IX_IF_CFG, 8'h00);
    for (int b = 0; b < 6; b++) begin
      v = 8'h40 | (8'h01 << b);
      wr(`IX_MAIN_CTRL, v);
      @(posedge pclk);
      check({miscorrection_fix_enable, auto_form_enable, erasure_enable, ecc_enable,
          encode_mode}, {v[5], v[4], v[3], v[1], v[0]});
      rd(`IX_MAIN_CTRL, v);
    end
  endtask
  // Pointer stepping, previous pointer, count down and reload from the next set.
  task automatic t_seq;
    wr(`IX_CUR_HI, 8'h80);
    wr(`IX_CUR_LO, 8'h05);
    wr(`IX_CUR_CNT, 8'h03);
    wr(`IX_NEXT_HI, 8'h80);
    wr(`IX_NEXT_LO, 8'h28);
    wr(`IX_NEXT_CNT, 8'h02);
    wr(`IX_SYNC_CTRL, 8'h40);
    wr(`IX_MAIN_CTRL, 8'hc4);
    frame(8'h12, 8'h34, 8'h60, 2);
    chk_mem(6, 8'h12, 8'h34);
    rd(`IX_CUR_LO, 8'h06);
    rd(`IX_PREV_LO, 8'h05);
    rd(`IX_CUR_CNT, 8'h02);
    frame(8'h56, 8'h78, 8'h60, 5);
    check(rl_n, 0);
    frame(8'h9a, 8'hbc, 8'h60, 2);
    check(rl_n, 1);
    chk_mem(40, 8'h9a, 8'hbc);
    rd(`IX_CUR_LO, 8'h28);
    rd(`IX_CUR_CNT, 8'h02);
    rd(`IX_PREV_LO, 8'h07);
    wr(`IX_NEXT_LO, 8'h50);
  endtask
  // Framing, divider codes, swap and clock polarity, with the pointer held.
  task automatic t_modes;
    byte_t cfg[4] = '{8'h00, 8'ha3, 8'h42, 8'he1};
    wr(`IX_CUR_HI, 8'h00);
    wr(`IX_CUR_LO, 8'h09);
    wr(`IX_CUR_CNT, 8'h80);
    for (int i = 0; i < 4; i++) begin
      frame(8'ha0 + 8'(i), 8'h5c ^ 8'(i), cfg[i], 2 + 3 * (i % 2));
      chk_mem(9, 8'ha0 + 8'(i), 8'h5c ^ 8'(i));
      rd(`IX_CUR_LO, 8'h09);
    end
  endtask
  // Write-inhibit, write request off, decoding off.
  task automatic t_inhibit;
    byte_t mc[3] = '{8'hc4, 8'hc0, 8'h40};
    int r0;
    for (int i = 0; i < 3; i++) begin
      wr(`IX_MAIN_CTRL, mc[i]);
      wr(`IX_CUR_HI, i == 0 ? 8'hc0 : 8'h80);
      wr(`IX_CUR_LO, 8'h03);
      wr(`IX_CUR_CNT, i == 0 ? 8'h40 : 8'h01);
      r0 = rl_n;
      frame(8'h11, 8'h22, 8'h60, 2);
      check(wr_n, 0);
      check(rl_n, r0);
      rd(`IX_CUR_LO, i == 0 ? 8'h04 : 8'h03);
    end
    wr(`IX_MAIN_CTRL, 8'hc4);
  endtask
  // Descrambling starts at offset 12; the sync byte stays plain.
  task automatic t_descr;
    wr(`IX_FMT_CTRL, 8'h02);
    wr(`IX_CUR_HI, 8'h00);
    wr(`IX_CUR_LO, 8'h02);
    wr(`IX_CUR_CNT, 8'h40);
    frame(8'h00, 8'h00, 8'h60, 2);
    chk_mem(2, 8'h01, 8'h80);
  endtask
  // Sub-header copies differ in their second byte; the select bit masks the second copy.
  task automatic t_subhdr;
    byte_t q[$];
    for (int s = 0; s < 2; s++) begin
      q = {8'h00};
      repeat (10) q.push_back(8'hff);
      q = {q, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
          8'h01, 8'h0f, 8'h03, 8'h04};
      wr(`IX_IF_CFG, (s == 1) ? 8'h70 : 8'h60);
      fe.send(q, 1'b0, 1'b0, 1, 1'b0, 2);
      repeat (4) @(posedge pclk);
      rd(`IX_HDR_ERR, (s == 1) ? 8'h00 : 8'h04);
    end
  endtask
  // Reset for 20 cycles, then the scenarios in turn.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_seq();
    t_modes();
    t_inhibit();
    t_descr();
    t_subhdr();
    give_verdict();
  end
  // Cuts a hang short well after the scenarios should have ended.
  initial begin
    repeat (50000) @(posedge pclk);
    fails++;
    give_verdict();
  end
endmodule // test_cd_sector_input_writer
